// ===== common/pisw_pkg.sv
// Constants, types and helpers for the peripheral interrupt and sleep block
package pisw_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int AW = 4;
  localparam int DW = 8;
  localparam int NSRC = 6;
  localparam int PC_W = 13;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [AW-1:0] OFS_EN_A = 4'h0;
  localparam logic [AW-1:0] OFS_EN_B = 4'h1;
  localparam logic [AW-1:0] OFS_REQ_A = 4'h2;
  localparam logic [AW-1:0] OFS_REQ_B = 4'h3;
  localparam logic [AW-1:0] OFS_CTRL = 4'h4;
  localparam logic [AW-1:0] OFS_STAT = 4'h5;

  // ----------------------------------------
  // Source index in the packed vectors
  // ----------------------------------------
  localparam int SRC_T1OVF = 0;
  localparam int SRC_UTX = 1;
  localparam int SRC_URX = 2;
  localparam int SRC_ADC = 3;
  localparam int SRC_T1GATE = 4;
  localparam int SRC_LCD = 5;

  // ----------------------------------------
  // Field positions and masks
  // ----------------------------------------
  localparam int A_T1GATE_BIT = 7;
  localparam int A_ADC_BIT = 6;
  localparam int A_URX_BIT = 5;
  localparam int A_UTX_BIT = 4;
  localparam int A_T1OVF_BIT = 0;
  localparam int B_LCD_BIT = 2;
  localparam logic [DW-1:0] MASK_A = 8'hf1;
  localparam logic [DW-1:0] MASK_B = 8'h04;
  localparam int CTRL_GIE_BIT = 7;
  localparam int CTRL_PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int STAT_TO_BIT = 4;
  localparam int STAT_PD_BIT = 3;
  localparam int STAT_SLP_BIT = 0;

  // ----------------------------------------
  // Reset values and fixed addresses
  // ----------------------------------------
  localparam logic PD_RST = 1'b1;
  localparam logic TO_RST = 1'b1;
  localparam logic [DW-1:0] ZERO8 = 8'h00;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;

  // Sleep sequencing states
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE} pisw_state_type;

  // Lay the packed sources out as register A
  function automatic logic [DW-1:0] to_reg_a(logic [NSRC-1:0] v);
    logic [DW-1:0] r;
    r = ZERO8;
    r[A_T1GATE_BIT] = v[SRC_T1GATE];
    r[A_ADC_BIT] = v[SRC_ADC];
    r[A_URX_BIT] = v[SRC_URX];
    r[A_UTX_BIT] = v[SRC_UTX];
    r[A_T1OVF_BIT] = v[SRC_T1OVF];
    return r;
  endfunction

  // Lay the packed sources out as register B
  function automatic logic [DW-1:0] to_reg_b(logic [NSRC-1:0] v);
    logic [DW-1:0] r;
    r = ZERO8;
    r[B_LCD_BIT] = v[SRC_LCD];
    return r;
  endfunction

  // Merge a register A write into the packed sources
  function automatic logic [NSRC-1:0] from_reg_a(logic [DW-1:0] d,
                                                 logic [NSRC-1:0] v);
    logic [NSRC-1:0] r;
    r = v;
    r[SRC_T1GATE] = d[A_T1GATE_BIT];
    r[SRC_ADC] = d[A_ADC_BIT];
    r[SRC_URX] = d[A_URX_BIT];
    r[SRC_UTX] = d[A_UTX_BIT];
    r[SRC_T1OVF] = d[A_T1OVF_BIT];
    return r;
  endfunction

  // Merge a register B write into the packed sources
  function automatic logic [NSRC-1:0] from_reg_b(logic [DW-1:0] d,
                                                 logic [NSRC-1:0] v);
    logic [NSRC-1:0] r;
    r = v;
    r[SRC_LCD] = d[B_LCD_BIT];
    return r;
  endfunction

endpackage

// ===== common/pisw_flag_if.sv
// Interface between the controller and its request flag bank
`timescale 1ns/10ps
`default_nettype none
interface pisw_flag_if
  import pisw_pkg::*;
  ();
  logic [NSRC-1:0] set_evt; // Raise requests, one bit per source
  logic wr_a; // Software write to request register A
  logic wr_b; // Software write to request register B
  logic [DW-1:0] wdata; // Software write data
  logic [NSRC-1:0] flags; // Pending requests

  modport bank (input set_evt, input wr_a, input wr_b, input wdata,
                output flags);
  modport ctrl (output set_evt, output wr_a, output wr_b, output wdata,
                input flags);
endinterface
`default_nettype wire

// ===== design/pisw_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module pisw_sync
  import pisw_pkg::*;
#(
  parameter int W = NSRC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out
);
  logic [W-1:0] ff1_r; // First stage, read by ff2 only
  logic [W-1:0] ff2_r; // Second stage
  logic [W-1:0] ff3_r; // Third stage
  logic [W-1:0] stable_r; // Accepted level

  // ----------------------------------------
  // Shift chain; a change counts once 2 and 3 agree
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ff1_r <= '0;
      ff2_r <= '0;
      ff3_r <= '0;
      stable_r <= '0;
    end else begin
      ff1_r <= async_in;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      // Keep the old level while the two stages disagree
      stable_r <= (~(ff2_r ^ ff3_r) & ff2_r) | ((ff2_r ^ ff3_r) & stable_r);
    end
  end

  assign level_out = stable_r;
endmodule
`default_nettype wire

// ===== design/pisw_flag_bank.sv
// Pending request flags with hardware set taking priority over writes
`timescale 1ns/10ps
`default_nettype none
module pisw_flag_bank
  import pisw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  pisw_flag_if.bank fl
);
  logic [NSRC-1:0] flags_r; // Pending flags
  logic [NSRC-1:0] flags_nxt; // Next pending flags

  // ----------------------------------------
  // Next value: software write, then events
  // ----------------------------------------
  always_comb begin
    flags_nxt = flags_r;
    if (fl.wr_a) begin
      flags_nxt = from_reg_a(fl.wdata, flags_nxt);
    end
    if (fl.wr_b) begin
      flags_nxt = from_reg_b(fl.wdata, flags_nxt);
    end
    // RULE6 set regardless of enables
    // An event in the clearing cycle is kept, never lost
    flags_nxt = flags_nxt | fl.set_evt;
  end

  // Flags clear on every reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign fl.flags = flags_r;
endmodule
`default_nettype wire

// ===== design/pisw_ctrl.sv
// Peripheral interrupt enables, flags, and sleep entry and wake-up control
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`default_nettype none
// How it works
// RULE1 - peripheral requests need peripheral enable too
// RULE2 - register A enables at 7,6,5,4,0
// RULE3 - register B holds only LCD enable
// RULE4 - request register A flags at 7,6,5,4,0
// RULE5 - request register B holds only LCD flag
// RULE6 - flags set regardless of any enable
// RULE7 - software clears flag before enabling source
// RULE8 - implemented bits read/write, reset to zero
// RULE9 - sleep clears power-down, sets expiry, stops CPU
// RULE10 - sleep entry clears watchdog, may keep counting
// RULE11 - slow oscillators and RC ADC keep running
// RULE12 - ports hold their drive state asleep
// RULE13 - sleep leaves other resets untouched
// RULE14 - wake by resets, watchdog or interrupts
// RULE15 - sleep prefetches program counter plus one
// RULE16 - wake needs source enable, not global
// RULE17 - next instruction runs before any vectoring
// RULE18 - software puts no-op after sleep if needed
// RULE19 - every wake-up clears the watchdog
// RULE20 - peripheral enable is control bit 6
// RULE21 - taken interrupt vectors to 0004h
// RULE22 - pending enabled flag makes sleep a no-op; the code does so only while the global enable is clear
// RULE23 - request is OR of flag AND enable
module pisw_ctrl
  import pisw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  input wire logic [NSRC-1:0] periph_evt,
  input wire logic [NSRC-1:0] wake_evt_async,
  input wire logic ext_wake_req,
  input wire logic wdt_timeout,
  input wire logic sleep_exec,
  input wire logic [PC_W-1:0] core_pc,
  input wire logic instr_retire,
  input wire logic wdt_sleep_en,
  input wire logic adc_rc_sel,
  output logic periph_irq_req,
  output logic irq_take,
  output logic [PC_W-1:0] irq_vector_addr,
  output logic [PC_W-1:0] prefetch_addr,
  output logic cpu_clk_en,
  output logic wdt_clear,
  output logic wdt_run,
  output logic lf_osc_run,
  output logic sec_osc_run,
  output logic cap_osc_run,
  output logic adc_clk_run,
  output logic io_hold,
  output logic wake_resume
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  pisw_flag_if fl (); // Link to the flag bank
  pisw_state_type state_r; // Sleep sequencer state
  logic [NSRC-1:0] en_r; // Per-source enables
  logic gie_r; // Global interrupt enable
  logic peripheral_irq_enable_r; // Peripheral interrupt enable
  logic pd_r; // Power-down status flag
  logic to_r; // Watchdog expiry status flag
  logic [NSRC-1:0] wake_lvl; // Synchronised wake levels
  logic [NSRC-1:0] wake_prev_r; // Previous wake levels
  logic [NSRC-1:0] flags; // Pending flags from the bank
  logic [DW-1:0] rd_val; // Read mux output
  logic [DW-1:0] rdata_r; // Read data register
  logic [PC_W-1:0] vec_r; // Vector address register
  logic [PC_W-1:0] pref_r; // Prefetch address register
  logic wdt_clear_r; // Watchdog clear pulse
  logic wake_r; // Wake pulse register
  logic wake_pend; // An enabled source is pending
  logic nop_cond; // Sleep must act as a no-op
  logic enter_sleep; // Sleep entry this cycle
  logic leave_sleep; // Wake-up this cycle
  logic asleep; // CPU clock is stopped

  // ----------------------------------------
  // Flag bank and async wake inputs
  // ----------------------------------------
  pisw_flag_bank u_bank (
    .clk(clk),
    .rst_n(rst_n),
    .fl(fl.bank)
  );

  // Peripherals on slow clocks raise levels while the CPU sleeps
  pisw_sync #(.W(NSRC)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(wake_evt_async),
    .level_out(wake_lvl)
  );

  // Remember the accepted level to find its rising edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_prev_r <= '0;
    end else begin
      wake_prev_r <= wake_lvl;
    end
  end

  // RULE6 events set flags unconditionally
  assign fl.set_evt = periph_evt | (wake_lvl & ~wake_prev_r);
  assign fl.wr_a = reg_wr && (reg_addr == OFS_REQ_A);
  assign fl.wr_b = reg_wr && (reg_addr == OFS_REQ_B);
  assign fl.wdata = reg_wdata;
  assign flags = fl.flags;

  // ----------------------------------------
  // Enable and control registers
  // ----------------------------------------
  // RULE8 writable enables, zero after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_r <= '0;
    end else if (reg_wr && reg_addr == OFS_EN_A) begin
      // RULE2 only the five defined bits are kept
      en_r <= from_reg_a(reg_wdata, en_r);
    end else if (reg_wr && reg_addr == OFS_EN_B) begin
      // RULE3 only the LCD bit is kept
      en_r <= from_reg_b(reg_wdata, en_r);
    end
  end

  // RULE20 peripheral enable sits in bit 6
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gie_r <= 1'b0;
      peripheral_irq_enable_r <= 1'b0;
    end else if (reg_wr && reg_addr == OFS_CTRL) begin
      gie_r <= reg_wdata[CTRL_GIE_BIT];
      peripheral_irq_enable_r <= reg_wdata[CTRL_PERIPHERAL_IRQ_ENABLE_BIT];
    end
  end

  // ----------------------------------------
  // Request and vectoring
  // ----------------------------------------
  // RULE23 OR of flag AND enable
  // RULE1 gated by the peripheral enable
  assign periph_irq_req = peripheral_irq_enable_r && ((flags & en_r) != '0);

  // RULE16 global enable plays no part in waking
  assign wake_pend = periph_irq_req || ext_wake_req;

  // RULE17 no vectoring until the resumed instruction retires
  assign irq_take = gie_r && periph_irq_req && (state_r == ST_RUN);

  // RULE21 taken interrupt loads the vector address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vec_r <= '0;
    end else if (irq_take) begin
      vec_r <= IRQ_VECTOR;
    end
  end
  assign irq_vector_addr = vec_r;

  // ----------------------------------------
  // Sleep sequencer
  // ----------------------------------------
  // RULE22 pending enabled source with global clear skips sleep
  assign nop_cond = wake_pend && !gie_r;
  assign enter_sleep = (state_r == ST_RUN) && sleep_exec && !nop_cond;
  // RULE14 watchdog or interrupt wake continues the program
  assign leave_sleep = (state_r == ST_SLEEP) && (wake_pend || wdt_timeout);

  // RULE13 reset acts the same asleep or awake
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_RUN;
    end else begin
      unique case (state_r)
        // Running: power-down instruction may enter sleep
        ST_RUN: begin
          if (enter_sleep) begin
            state_r <= ST_SLEEP;
          end
        end
        // Clock stopped, waiting for a wake source
        ST_SLEEP: begin
          if (leave_sleep) begin
            state_r <= ST_WAKE;
          end
        end
        // Clock running, next instruction still to retire
        ST_WAKE: begin
          if (instr_retire) begin
            state_r <= ST_RUN;
          end
        end
      endcase
    end
  end

  // RULE9 status flags change on entry only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pd_r <= PD_RST;
      to_r <= TO_RST;
    end else if (enter_sleep) begin
      pd_r <= 1'b0;
      to_r <= 1'b1;
    end
  end

  // RULE10 clear on entry
  // RULE19 clear again on every wake
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wdt_clear_r <= 1'b0;
    end else begin
      wdt_clear_r <= enter_sleep || leave_sleep;
    end
  end
  assign wdt_clear = wdt_clear_r;

  // One-cycle notice that execution resumes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= leave_sleep;
    end
  end
  assign wake_resume = wake_r;

  // RULE15 latch the address after the sleep instruction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pref_r <= '0;
    end else if (sleep_exec) begin
      pref_r <= core_pc + PC_STEP;
    end
  end
  assign prefetch_addr = pref_r;

  // ----------------------------------------
  // Clock and pin controls
  // ----------------------------------------
  assign asleep = (state_r == ST_SLEEP);
  // RULE9 CPU clock stops while asleep
  assign cpu_clk_en = !asleep;
  // RULE10 watchdog counts asleep only if allowed
  assign wdt_run = !asleep || wdt_sleep_en;
  // RULE11 slow oscillators are never stopped by sleep
  assign lf_osc_run = 1'b1;
  assign sec_osc_run = 1'b1;
  assign cap_osc_run = 1'b1;
  // RULE11 ADC keeps going only on its own RC clock
  assign adc_clk_run = !asleep || adc_rc_sel;
  // RULE12 port latches freeze while asleep
  assign io_hold = asleep;

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  // Unmapped offsets and unused bits read as zero
  always_comb begin
    rd_val = ZERO8;
    unique case (reg_addr)
      // RULE2 enable layout A
      OFS_EN_A: rd_val = to_reg_a(en_r);
      // RULE3 enable layout B
      OFS_EN_B: rd_val = to_reg_b(en_r);
      // RULE4 flag layout A
      OFS_REQ_A: rd_val = to_reg_a(flags);
      // RULE5 flag layout B
      OFS_REQ_B: rd_val = to_reg_b(flags);
      OFS_CTRL: begin
        rd_val[CTRL_GIE_BIT] = gie_r;
        rd_val[CTRL_PERIPHERAL_IRQ_ENABLE_BIT] = peripheral_irq_enable_r;
      end
      OFS_STAT: begin
        rd_val[STAT_TO_BIT] = to_r;
        rd_val[STAT_PD_BIT] = pd_r;
        rd_val[STAT_SLP_BIT] = asleep;
      end
      default: rd_val = ZERO8;
    endcase
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= ZERO8;
    end else begin
      rdata_r <= reg_rd ? rd_val : ZERO8;
    end
  end
  assign reg_rdata = rdata_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_peripheral_irq_enable_gate: assert property ( // RULE1
    !peripheral_irq_enable_r |-> !periph_irq_req && !irq_take)
    else $error("request without peripheral enable");

  a_en_a_read: assert property ( // RULE2
    reg_rd && reg_addr == OFS_EN_A |=> (reg_rdata & ~MASK_A) == ZERO8)
    else $error("enable A reserved bits not zero");

  a_en_b_read: assert property ( // RULE3
    reg_rd && reg_addr == OFS_EN_B |=> (reg_rdata & ~MASK_B) == ZERO8)
    else $error("enable B reserved bits not zero");

  a_req_a_read: assert property ( // RULE4
    reg_rd && reg_addr == OFS_REQ_A
    |=> reg_rdata[A_ADC_BIT] == $past(flags[SRC_ADC])
        && (reg_rdata & ~MASK_A) == ZERO8)
    else $error("request A layout wrong");

  a_req_b_read: assert property ( // RULE5
    reg_rd && reg_addr == OFS_REQ_B
    |=> reg_rdata == ($past(flags[SRC_LCD]) ? MASK_B : ZERO8))
    else $error("request B layout wrong");

  a_flag_set: assert property ( // RULE6
    periph_evt != '0 |=> (flags & $past(periph_evt)) == $past(periph_evt))
    else $error("event did not set its flag");

  a_en_write: assert property ( // RULE8
    reg_wr && reg_addr == OFS_EN_A
    |=> to_reg_a(en_r) == ($past(reg_wdata) & MASK_A))
    else $error("enable A write not stored");

  a_sleep_entry: assert property ( // RULE9
    enter_sleep |=> !pd_r && to_r && !cpu_clk_en && wdt_clear)
    else $error("sleep entry effects missing");

  a_osc_keep: assert property ( // RULE11
    asleep |-> lf_osc_run && sec_osc_run && adc_clk_run == adc_rc_sel)
    else $error("oscillator control wrong in sleep");

  a_io_hold: assert property ( // RULE12
    asleep |-> io_hold)
    else $error("ports not held in sleep");

  a_prefetch: assert property ( // RULE15
    sleep_exec |=> prefetch_addr == $past(core_pc) + PC_STEP)
    else $error("prefetch address wrong");

  a_wake_enable: assert property ( // RULE16
    asleep && !wake_pend && !wdt_timeout |=> asleep)
    else $error("woke without an enabled source");

  // Retire may come in the first cycle after wake, so only the
  // cycles before it are held quiet
  a_resume_order: assert property ( // RULE17
    (leave_sleep || (state_r == ST_WAKE && !instr_retire)) |=> !irq_take)
    else $error("vectored before next instruction");

  a_wake_wdt_clr: assert property ( // RULE19
    asleep && wdt_timeout |=> wdt_clear && wake_resume ##1 !wdt_clear)
    else $error("wake did not clear watchdog once");

  a_vector_addr: assert property ( // RULE21
    irq_take |=> irq_vector_addr == IRQ_VECTOR)
    else $error("vector address wrong");

  a_sleep_nop: assert property ( // RULE22
    state_r == ST_RUN && sleep_exec && nop_cond
    |=> state_r == ST_RUN && pd_r == $past(pd_r) && !wdt_clear)
    else $error("sleep not a no-op with pending source");

  // Main scenarios
  c_enter_sleep: cover property (enter_sleep);
  c_irq_wake: cover property (asleep && periph_irq_req ##1 !asleep);
  c_sleep_nop: cover property (sleep_exec && nop_cond);
  c_irq_take: cover property (irq_take);

endmodule
`default_nettype wire

// ===== sim/pisw_periph_model.sv
// Behavioural peripherals that raise interrupt requests toward the block
`timescale 1ns/10ps
`default_nettype none
module pisw_periph_model
  import pisw_pkg::*;
(
  input wire logic clk,
  output logic [NSRC-1:0] periph_evt,
  output logic [NSRC-1:0] wake_evt_async
);
  // ----------------------------------------
  // Request drivers
  // ----------------------------------------
  // Idle with no request raised
  initial begin
    periph_evt = 6'h00;
    wake_evt_async = 6'h00;
  end

  // One-cycle same-clock request pulse, launched just after an edge
  task automatic pulse(input logic [NSRC-1:0] m);
    @(posedge clk);
    periph_evt <= m;
    @(posedge clk);
    periph_evt <= 6'h00;
  endtask

  // Sleep-capable source: level changes away from the edge, as a
  // peripheral on its own oscillator would, so the sync path is exercised
  task automatic level(input logic [NSRC-1:0] m);
    @(posedge clk);
    #3;
    wake_evt_async = m;
  endtask
endmodule
`default_nettype wire

// ===== sim/tb_peripheral_irq_and_sleep_wake.sv
// Self-checking testbench for the peripheral interrupt and sleep block
`timescale 1ns/10ps
`default_nettype none
module tb_peripheral_irq_and_sleep_wake;
  import pisw_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [AW-1:0] reg_addr = 4'h0;
  logic [DW-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ext_wake_req = 1'b0;
  logic wdt_timeout = 1'b0;
  logic sleep_exec = 1'b0;
  logic [PC_W-1:0] core_pc = 13'h0000;
  logic instr_retire = 1'b0;
  logic wdt_sleep_en = 1'b0;
  logic adc_rc_sel = 1'b0;
  logic [DW-1:0] reg_rdata;
  logic [NSRC-1:0] periph_evt, wake_evt_async;
  logic periph_irq_req, irq_take, cpu_clk_en, wdt_clear, wdt_run;
  logic lf_osc_run, sec_osc_run, cap_osc_run, adc_clk_run, io_hold;
  logic wake_resume;
  logic [PC_W-1:0] irq_vector_addr, prefetch_addr;
  int n_fail = 0;
  int comparisons = 0;

  // 8 ns period for the 125 MHz system clock
  always #4 clk = ~clk;

  pisw_periph_model pisw_periph_model_i (.clk(clk),
    .periph_evt(periph_evt), .wake_evt_async(wake_evt_async));

  pisw_ctrl pisw_ctrl_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .periph_evt(periph_evt),
    .wake_evt_async(wake_evt_async), .ext_wake_req(ext_wake_req),
    .wdt_timeout(wdt_timeout), .sleep_exec(sleep_exec), .core_pc(core_pc),
    .instr_retire(instr_retire), .wdt_sleep_en(wdt_sleep_en),
    .adc_rc_sel(adc_rc_sel), .periph_irq_req(periph_irq_req),
    .irq_take(irq_take), .irq_vector_addr(irq_vector_addr),
    .prefetch_addr(prefetch_addr), .cpu_clk_en(cpu_clk_en),
    .wdt_clear(wdt_clear), .wdt_run(wdt_run), .lf_osc_run(lf_osc_run),
    .sec_osc_run(sec_osc_run), .cap_osc_run(cap_osc_run),
    .adc_clk_run(adc_clk_run), .io_hold(io_hold),
    .wake_resume(wake_resume));

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  // Compare with case equality so an unknown never matches
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e,
                    input string nm);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
  endtask

  // Power-down pulse; the edge after it must show the asleep state
  task automatic go_sleep(input logic [PC_W-1:0] pc);
    @(posedge clk);
    sleep_exec <= 1'b1;
    core_pc <= pc;
    @(posedge clk);
    sleep_exec <= 1'b0;
    #1;
    chk("cpu_clk_en", 1'b0, cpu_clk_en);
    chk("io_hold", 1'b1, io_hold);
    chk("wdt_clear", 1'b1, wdt_clear);
    chk("prefetch", PC_W'(pc + PC_STEP), prefetch_addr);
    chk("osc", 3'h7, {lf_osc_run, sec_osc_run, cap_osc_run});
  endtask

  // Bounded wait for wake; pulses must appear with the clock restart
  task automatic wait_wake;
    int k;
    for (k = 0; k < 20 && cpu_clk_en !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk("wake cpu_clk_en", 1'b1, cpu_clk_en);
    chk("wake wdt_clear", 1'b1, wdt_clear);
    chk("wake_resume", 1'b1, wake_resume);
    chk("wake io_hold", 1'b0, io_hold);
  endtask

  // The instruction after sleep retires
  // no-op word after sleep
  task automatic retire;
    @(posedge clk);
    instr_retire <= 1'b1;
    @(posedge clk);
    instr_retire <= 1'b0;
    #1;
  endtask

  // Software clears flags before enables, then everything else
  task automatic clr_all;
    wr(OFS_REQ_A, 8'h00);
    wr(OFS_REQ_B, 8'h00);
    wr(OFS_EN_A, 8'h00);
    wr(OFS_EN_B, 8'h00);
    wr(OFS_CTRL, 8'h00);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset values, read-only status and an unmapped place
  task automatic t_regs;
    rd(OFS_EN_A, 8'h00, "en_a reset");
    rd(OFS_REQ_B, 8'h00, "req_b reset");
    rd(OFS_STAT, 8'h18, "stat reset");
    wr(OFS_EN_A, 8'hff);
    wr(OFS_EN_B, 8'hff);
    wr(OFS_REQ_A, 8'hff);
    wr(OFS_REQ_B, 8'hff);
    wr(OFS_STAT, 8'h00);
    wr(4'h9, 8'hff);
    rd(OFS_EN_A, 8'hf1, "en_a");
    rd(OFS_EN_B, 8'h04, "en_b");
    rd(OFS_REQ_A, 8'hf1, "req_a");
    rd(OFS_REQ_B, 8'h04, "req_b");
    rd(OFS_STAT, 8'h18, "stat ro");
    rd(4'h9, 8'h00, "unmapped");
    clr_all;
  endtask

  // Flags set with enables off; request needs both enables
  task automatic t_flags;
    pisw_periph_model_i.pulse(6'h3f);
    rd(OFS_REQ_A, 8'hf1, "evt req_a");
    rd(OFS_REQ_B, 8'h04, "evt req_b");
    wr(OFS_CTRL, 8'h40);
    #1;
    chk("req no src en", 1'b0, periph_irq_req);
    wr(OFS_EN_A, 8'h01);
    #1;
    chk("req on", 1'b1, periph_irq_req);
    chk("take no gie", 1'b0, irq_take);
    wr(OFS_CTRL, 8'h80);
    #1;
    chk("req no peripheral_irq_enable", 1'b0, periph_irq_req);
    wr(OFS_CTRL, 8'hc0);
    #1;
    chk("take", 1'b1, irq_take);
    @(posedge clk);
    #1;
    chk("vector", 13'h0004, irq_vector_addr);
    clr_all;
  endtask

  // Enabled flag pending with global enable clear: sleep is a no-op
  task automatic t_nop;
    wr(OFS_CTRL, 8'h40);
    wr(OFS_EN_B, 8'h04);
    pisw_periph_model_i.pulse(6'h20);
    @(posedge clk);
    sleep_exec <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
    #1;
    chk("nop cpu_clk_en", 1'b1, cpu_clk_en);
    chk("nop wdt_clear", 1'b0, wdt_clear);
    rd(OFS_STAT, 8'h18, "nop stat");
    clr_all;
  endtask

  // Sleep, then wake from the asynchronous LCD request
  task automatic t_async;
    wr(OFS_EN_B, 8'h04);
    wr(OFS_CTRL, 8'h40);
    wdt_sleep_en <= 1'b1;
    adc_rc_sel <= 1'b0;
    go_sleep(13'h0123);
    chk("wdt_run", 1'b1, wdt_run);
    chk("adc_clk_run", 1'b0, adc_clk_run);
    rd(OFS_STAT, 8'h11, "sleep stat");
    pisw_periph_model_i.level(6'h20);
    wait_wake;
    pisw_periph_model_i.level(6'h00);
    retire;
    rd(OFS_REQ_B, 8'h04, "async flag");
    clr_all;
  endtask

  // Watchdog wake, then external wake, neither with enables set
  task automatic t_wdt_ext;
    wdt_sleep_en <= 1'b0;
    adc_rc_sel <= 1'b1;
    go_sleep(13'h1fff);
    chk("wdt_run off", 1'b0, wdt_run);
    chk("adc_clk_run on", 1'b1, adc_clk_run);
    @(posedge clk);
    wdt_timeout <= 1'b1;
    wait_wake;
    wdt_timeout <= 1'b0;
    retire;
    go_sleep(13'h0040);
    @(posedge clk);
    ext_wake_req <= 1'b1;
    wait_wake;
    ext_wake_req <= 1'b0;
    retire;
  endtask

  // Global enable set: next instruction retires before vectoring
  task automatic t_gie;
    wr(OFS_EN_A, 8'h80);
    wr(OFS_CTRL, 8'hc0);
    go_sleep(13'h0200);
    pisw_periph_model_i.pulse(6'h10);
    wait_wake;
    chk("take held", 1'b0, irq_take);
    retire;
    chk("take after", 1'b1, irq_take);
    clr_all;
  endtask

  // ----------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------
  task automatic conclude;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Whole run needs well under 1000 cycles; 5000 cuts a hang short
  initial begin
    #40000;
    n_fail++;
    conclude;
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_flags;
    t_nop;
    t_async;
    t_wdt_ext;
    t_gie;
    conclude;
  end
endmodule
`default_nettype wire
